// file: src/prm_pkg.sv
// constants for the peripheral pin remap block: register offsets, field positions, codes.
// assumes a single-slave ahb-lite bus on hclk; registers sit at chosen word offsets.
// Behaviour
// RULE1 - second converter preempted trigger: 0 routes ext line 15, 1 timer channel 4
// RULE2 - bit 5 first converter regular trigger: 0 ext line 11, 1 timer trigger out
// RULE3 - bit 4 first converter preempted trigger: 0 ext line 15, 1 timer channel 4
// RULE4 - software keeps bits 7:6 of register seven at reset value
// RULE5 - bit 3 enables serial flash interface and hands it the pins
// RULE6 - serial flash map codes 000 and 001 move data lines 0 and 1 only
// RULE7 - bits 31:28 place uart eight lines; codes 0 and 1 valid
// RULE8 - bits 27:24 place uart seven lines; codes 0 and 1 valid
// RULE9 - bits 23:20 place usart six lines; codes 0 and 1 valid
// RULE10 - bit 19 drives timestamp pulse onto its pin only when set
// RULE11 - bit 18 picks mii when 0, rmii when 1
// RULE12 - bits 17:16 pick ethernet receive pin group 0 or 1
// RULE13 - ethernet fields exist only on the variant with the ethernet controller
// RULE14 - software keeps bits 15:0 of register eight at reset value
// RULE15 - bit 9 second converter regular trigger: 0 ext line 11, 1 timer trigger out
// RULE16 - all fields reset to zero; new value steers routing next cycle
package prm_pkg;
	localparam logic [11:0] REG7_OFFSET = 12'h000;
	localparam logic [11:0] REG8_OFFSET = 12'h004;
	localparam logic [31:0] REG_RESET = 32'h00000000;
	// writable masks; reserved bits stay zero
	localparam logic [31:0] REG7_WMASK = 32'h0000033F;
	localparam logic [31:0] REG8_WMASK_ETH = 32'hFFFF0000;
	localparam logic [31:0] REG8_WMASK_NOETH = 32'hFFF00000;
	localparam int C2_REG_BIT = 9;
	localparam int C2_PRE_BIT = 8;
	localparam int C1_REG_BIT = 5;
	localparam int C1_PRE_BIT = 4;
	localparam int SF_EN_BIT = 3;
	localparam int SF_MAP_LSB = 0;
	localparam int U8_LSB = 28;
	localparam int U7_LSB = 24;
	localparam int U6_LSB = 20;
	localparam int PPS_BIT = 19;
	localparam int RMII_BIT = 18;
	localparam int ETH_MAP_LSB = 16;
	localparam logic [2:0] SF_MAP_A = 3'h0;
	localparam logic [2:0] SF_MAP_B = 3'h1;
	localparam logic [3:0] PAIR_A = 4'h0;
	localparam logic [3:0] PAIR_B = 4'h1;
	localparam logic [1:0] ETH_MAP_A = 2'h0;
	localparam logic [1:0] ETH_MAP_B = 2'h1;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	// 2-bit one-hot pin choice: bit0 first pin set, bit1 alternate, 0 none
	function automatic logic [1:0] pair_sel(input logic [3:0] code);
		pair_sel = {code == PAIR_B, code == PAIR_A};
	endfunction : pair_sel
endpackage : prm_pkg

// file: src/prm_ahb_slave.sv
// ahb-lite slave front end: captures the address phase; the zero-wait OKAY response is driven in prm_top.
// assumes a single master; only word transfers are expected.
`timescale 1ns/100ps
module prm_ahb_slave (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [11:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	output logic wr_pend,
	output logic rd_pend,
	output logic [11:0] addr_q
);
	wire take = hsel && hready && htrans[1];
	wire word_ok = hsize == prm_pkg::HSIZE_WORD;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			rd_pend <= 1'b0;
			addr_q <= 12'h000;
		end else if (hready) begin
			wr_pend <= take && hwrite && word_ok;
			rd_pend <= take && !hwrite;
			addr_q <= take ? haddr : addr_q;
		end
	end
endmodule : prm_ahb_slave

// file: src/prm_route.sv
// registered routing of trigger selections and the timestamp pulse pin gate from the two remap words.
// assumes trigger sources are already synchronous to hclk.
`timescale 1ns/100ps
module prm_route (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [31:0] reg7,
	input wire logic [31:0] reg8,
	input wire logic ext_int_line_eleven,
	input wire logic ext_int_line_fifteen,
	input wire logic adv_timer_trigger_out,
	input wire logic adv_timer_ch4,
	input wire logic ts_pulse,
	output logic conv1_regular_trig,
	output logic conv1_preempt_trig,
	output logic conv2_regular_trig,
	output logic conv2_preempt_trig,
	output logic ts_pulse_pin
);
	wire c1r = reg7[prm_pkg::C1_REG_BIT] ? adv_timer_trigger_out : ext_int_line_eleven; // [RULE2]
	wire c1p = reg7[prm_pkg::C1_PRE_BIT] ? adv_timer_ch4 : ext_int_line_fifteen; // [RULE3]
	wire c2r = reg7[prm_pkg::C2_REG_BIT] ? adv_timer_trigger_out : ext_int_line_eleven; // [RULE15]
	wire c2p = reg7[prm_pkg::C2_PRE_BIT] ? adv_timer_ch4 : ext_int_line_fifteen; // [RULE1]
	wire pps = reg8[prm_pkg::PPS_BIT] & ts_pulse; // [RULE10]

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			conv1_regular_trig <= 1'b0;
			conv1_preempt_trig <= 1'b0;
			conv2_regular_trig <= 1'b0;
			conv2_preempt_trig <= 1'b0;
			ts_pulse_pin <= 1'b0;
		end else begin
			conv1_regular_trig <= c1r;
			conv1_preempt_trig <= c1p;
			conv2_regular_trig <= c2r;
			conv2_preempt_trig <= c2p;
			ts_pulse_pin <= pps;
		end
	end
endmodule : prm_route

// file: src/prm_top.sv
// top of the peripheral pin remap block: ahb-lite registers and decoded pin choices.
// assumes one clock hclk and trigger sources synchronous to it.
//
// Local design decisions: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/100ps
module prm_top #(
	parameter bit HAS_ETH = 1'b1
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [11:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic ext_int_line_eleven,
	input wire logic ext_int_line_fifteen,
	input wire logic adv_timer_trigger_out,
	input wire logic adv_timer_ch4,
	input wire logic ts_pulse,
	output logic conv1_regular_trig,
	output logic conv1_preempt_trig,
	output logic conv2_regular_trig,
	output logic conv2_preempt_trig,
	output logic ts_pulse_pin,
	output logic serial_flash_if_enable,
	output logic [1:0] serial_flash_pin_map,
	output logic [1:0] uart_eight_pin_map,
	output logic [1:0] uart_seven_pin_map,
	output logic [1:0] usart_six_pin_map,
	output logic eth_rmii_mode,
	output logic [1:0] eth_rx_pin_map
);
	logic [31:0] reg7_r;
	logic [31:0] reg8_r;
	logic [31:0] reg7_nxt;
	logic [31:0] reg8_nxt;
	logic [31:0] rdata_nxt;
	logic wr_pend;
	logic rd_pend;
	logic [11:0] addr_q;

	prm_ahb_slave u_slave (
		.hclk(hclk),
		.hresetn(hresetn),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hready(hready),
		.wr_pend(wr_pend),
		.rd_pend(rd_pend),
		.addr_q(addr_q)
	);

	// ethernet fields vanish on the variant without the controller
	localparam logic [31:0] REG8_WMASK = HAS_ETH ? prm_pkg::REG8_WMASK_ETH
		: prm_pkg::REG8_WMASK_NOETH; // [RULE13]

	wire hit7 = addr_q == prm_pkg::REG7_OFFSET;
	wire hit8 = addr_q == prm_pkg::REG8_OFFSET;
	wire take_rd = hsel && hready && htrans == prm_pkg::HTRANS_NONSEQ && !hwrite;
	// reserved bits are masked off so a careless write cannot disturb them
	assign reg7_nxt = (wr_pend && hit7) ? (hwdata & prm_pkg::REG7_WMASK) : reg7_r; // [RULE4]
	assign reg8_nxt = (wr_pend && hit8) ? (hwdata & REG8_WMASK) : reg8_r; // [RULE14]
	// read data is registered to keep hrdata straight from a flop; unmapped reads zero
	wire hit7_a = haddr == prm_pkg::REG7_OFFSET;
	wire hit8_a = haddr == prm_pkg::REG8_OFFSET;
	assign rdata_nxt = !take_rd ? hrdata : hit7_a ? reg7_nxt : hit8_a ? reg8_nxt : 32'h00000000;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			reg7_r <= prm_pkg::REG_RESET; // [RULE16]
			reg8_r <= prm_pkg::REG_RESET; // [RULE16]
			hrdata <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			reg7_r <= reg7_nxt; // [RULE16]
			reg8_r <= reg8_nxt;
			hrdata <= rdata_nxt;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	wire [2:0] sf_code = reg7_r[prm_pkg::SF_MAP_LSB +: 3];
	wire [1:0] sf_map = {sf_code == prm_pkg::SF_MAP_B, sf_code == prm_pkg::SF_MAP_A}; // [RULE6]
	wire [1:0] u8_map = prm_pkg::pair_sel(reg8_r[prm_pkg::U8_LSB +: 4]); // [RULE7]
	wire [1:0] u7_map = prm_pkg::pair_sel(reg8_r[prm_pkg::U7_LSB +: 4]); // [RULE8]
	wire [1:0] u6_map = prm_pkg::pair_sel(reg8_r[prm_pkg::U6_LSB +: 4]); // [RULE9]
	wire [1:0] eth_code = reg8_r[prm_pkg::ETH_MAP_LSB +: 2];
	wire [1:0] eth_map = {eth_code == prm_pkg::ETH_MAP_B, eth_code == prm_pkg::ETH_MAP_A}; // [RULE12]

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			serial_flash_if_enable <= 1'b0;
			serial_flash_pin_map <= 2'h0;
			uart_eight_pin_map <= 2'h0;
			uart_seven_pin_map <= 2'h0;
			usart_six_pin_map <= 2'h0;
			eth_rmii_mode <= 1'b0;
			eth_rx_pin_map <= 2'h0;
		end else begin
			serial_flash_if_enable <= reg7_r[prm_pkg::SF_EN_BIT]; // [RULE5]
			serial_flash_pin_map <= reg7_r[prm_pkg::SF_EN_BIT] ? sf_map : 2'h0; // [RULE5]
			uart_eight_pin_map <= u8_map;
			uart_seven_pin_map <= u7_map;
			usart_six_pin_map <= u6_map;
			eth_rmii_mode <= reg8_r[prm_pkg::RMII_BIT]; // [RULE11]
			eth_rx_pin_map <= eth_map;
		end
	end

	prm_route u_route (
		.hclk(hclk),
		.hresetn(hresetn),
		.reg7(reg7_r),
		.reg8(reg8_r),
		.ext_int_line_eleven(ext_int_line_eleven),
		.ext_int_line_fifteen(ext_int_line_fifteen),
		.adv_timer_trigger_out(adv_timer_trigger_out),
		.adv_timer_ch4(adv_timer_ch4),
		.ts_pulse(ts_pulse),
		.conv1_regular_trig(conv1_regular_trig),
		.conv1_preempt_trig(conv1_preempt_trig),
		.conv2_regular_trig(conv2_regular_trig),
		.conv2_preempt_trig(conv2_preempt_trig),
		.ts_pulse_pin(ts_pulse_pin)
	);

	// every output flop still holds its reset value at the first edge after release,
	// so checks that look back one edge only start once that edge saw reset high
	sequence s_live;
		$past(hresetn);
	endsequence : s_live

	sequence s_live2;
		$past(hresetn, 2) && $past(hresetn);
	endsequence : s_live2

	sequence s_wr8;
		wr_pend && hit8;
	endsequence : s_wr8

	property p_conv1_reg;
		@(posedge hclk) disable iff (!hresetn)
		s_live |-> conv1_regular_trig == $past(reg7_r[prm_pkg::C1_REG_BIT]
			? adv_timer_trigger_out : ext_int_line_eleven);
	endproperty : p_conv1_reg
	a_conv1_route: assert property (p_conv1_reg) // [RULE2]
		else $error("conv1 regular trigger misrouted");

	property p_conv1_pre;
		@(posedge hclk) disable iff (!hresetn)
		s_live |-> conv1_preempt_trig == $past(reg7_r[prm_pkg::C1_PRE_BIT]
			? adv_timer_ch4 : ext_int_line_fifteen);
	endproperty : p_conv1_pre
	a_conv1_pre: assert property (p_conv1_pre) // [RULE3]
		else $error("conv1 preempted trigger misrouted");

	property p_conv2_pre;
		@(posedge hclk) disable iff (!hresetn)
		s_live |-> conv2_preempt_trig == $past(reg7_r[prm_pkg::C2_PRE_BIT]
			? adv_timer_ch4 : ext_int_line_fifteen);
	endproperty : p_conv2_pre
	a_conv2_pre: assert property (p_conv2_pre) // [RULE1]
		else $error("conv2 preempted trigger misrouted");

	property p_conv2_reg;
		@(posedge hclk) disable iff (!hresetn)
		s_live |-> conv2_regular_trig == $past(reg7_r[prm_pkg::C2_REG_BIT]
			? adv_timer_trigger_out : ext_int_line_eleven);
	endproperty : p_conv2_reg
	a_conv2_reg: assert property (p_conv2_reg) // [RULE15]
		else $error("conv2 regular trigger misrouted");

	property p_pps_gate;
		@(posedge hclk) disable iff (!hresetn)
		s_live ##0 ts_pulse_pin |-> $past(reg8_r[prm_pkg::PPS_BIT]);
	endproperty : p_pps_gate
	a_pps_gate: assert property (p_pps_gate) // [RULE10]
		else $error("pulse on pin while disabled");

	property p_pps_pass;
		@(posedge hclk) disable iff (!hresetn)
		s_live ##0 $past(reg8_r[prm_pkg::PPS_BIT]) |-> ts_pulse_pin == $past(ts_pulse);
	endproperty : p_pps_pass
	a_pps_pass: assert property (p_pps_pass) // [RULE10]
		else $error("enabled pulse not passed to pin");

	property p_reserved_seven;
		@(posedge hclk) disable iff (!hresetn)
		(reg7_r & ~prm_pkg::REG7_WMASK) == prm_pkg::REG_RESET;
	endproperty : p_reserved_seven
	a_reserved_seven: assert property (p_reserved_seven) // [RULE4]
		else $error("reg7 reserved set");

	property p_reserved_eight;
		@(posedge hclk) disable iff (!hresetn)
		(reg8_r & ~REG8_WMASK) == prm_pkg::REG_RESET;
	endproperty : p_reserved_eight
	a_reserved_eight: assert property (p_reserved_eight) // [RULE14]
		else $error("reg8 reserved set");

	// a write lands at the end of its data phase, the mode flop follows one edge later
	property p_write_effect;
		@(posedge hclk) disable iff (!hresetn)
		s_wr8 |=> ##1 eth_rmii_mode == $past(hwdata[prm_pkg::RMII_BIT] & HAS_ETH, 2);
	endproperty : p_write_effect
	a_write_effect: assert property (p_write_effect) // [RULE11]
		else $error("rmii select not applied");

	property p_uart_map;
		@(posedge hclk) disable iff (!hresetn)
		s_live ##0 $past(reg8_r[prm_pkg::U8_LSB +: 4]) > prm_pkg::PAIR_B
			|-> uart_eight_pin_map == 2'h0;
	endproperty : p_uart_map
	a_uart_map: assert property (p_uart_map) // [RULE7]
		else $error("unused uart code mapped");

	property p_uart_eight_used;
		@(posedge hclk) disable iff (!hresetn)
		s_live |-> uart_eight_pin_map == {$past(reg8_r[prm_pkg::U8_LSB +: 4]) == prm_pkg::PAIR_B,
			$past(reg8_r[prm_pkg::U8_LSB +: 4]) == prm_pkg::PAIR_A};
	endproperty : p_uart_eight_used
	a_uart_eight_pair: assert property (p_uart_eight_used) // [RULE7]
		else $error("uart eight pin pair wrong");

	property p_uart_seven;
		@(posedge hclk) disable iff (!hresetn)
		s_live |-> uart_seven_pin_map == {$past(reg8_r[prm_pkg::U7_LSB +: 4]) == prm_pkg::PAIR_B,
			$past(reg8_r[prm_pkg::U7_LSB +: 4]) == prm_pkg::PAIR_A};
	endproperty : p_uart_seven
	a_uart_seven_pair: assert property (p_uart_seven) // [RULE8]
		else $error("uart seven pin pair wrong");

	property p_usart_six;
		@(posedge hclk) disable iff (!hresetn)
		s_live |-> usart_six_pin_map == {$past(reg8_r[prm_pkg::U6_LSB +: 4]) == prm_pkg::PAIR_B,
			$past(reg8_r[prm_pkg::U6_LSB +: 4]) == prm_pkg::PAIR_A};
	endproperty : p_usart_six
	a_usart_six_pair: assert property (p_usart_six) // [RULE9]
		else $error("usart six pin pair wrong");

	property p_sf_enable;
		@(posedge hclk) disable iff (!hresetn)
		s_live |-> serial_flash_if_enable == $past(reg7_r[prm_pkg::SF_EN_BIT]);
	endproperty : p_sf_enable
	a_sf_enable: assert property (p_sf_enable) // [RULE5]
		else $error("serial flash enable not applied");

	// a disabled interface must not claim any pins
	property p_sf_off;
		@(posedge hclk) disable iff (!hresetn)
		!serial_flash_if_enable |-> serial_flash_pin_map == 2'h0;
	endproperty : p_sf_off
	a_sf_pins_off: assert property (p_sf_off) // [RULE5]
		else $error("serial flash pins claimed while off");

	property p_sf_map;
		@(posedge hclk) disable iff (!hresetn)
		s_live ##0 serial_flash_if_enable |-> serial_flash_pin_map ==
			{$past(sf_code) == prm_pkg::SF_MAP_B, $past(sf_code) == prm_pkg::SF_MAP_A};
	endproperty : p_sf_map
	a_sf_pin_map: assert property (p_sf_map) // [RULE6]
		else $error("serial flash pin map wrong");

	property p_rmii_follow;
		@(posedge hclk) disable iff (!hresetn)
		s_live |-> eth_rmii_mode == $past(reg8_r[prm_pkg::RMII_BIT]);
	endproperty : p_rmii_follow
	a_rmii_follow: assert property (p_rmii_follow) // [RULE11]
		else $error("interface type not applied");

	property p_eth_map;
		@(posedge hclk) disable iff (!hresetn)
		s_live |-> eth_rx_pin_map ==
			{$past(eth_code) == prm_pkg::ETH_MAP_B, $past(eth_code) == prm_pkg::ETH_MAP_A};
	endproperty : p_eth_map
	a_eth_rx_map: assert property (p_eth_map) // [RULE12]
		else $error("ethernet receive pins wrong");

	property p_eth_absent;
		@(posedge hclk) disable iff (!hresetn)
		!HAS_ETH |-> reg8_r[prm_pkg::PPS_BIT -: 4] == 4'h0;
	endproperty : p_eth_absent
	a_eth_absent: assert property (p_eth_absent) // [RULE13]
		else $error("ethernet field set on variant without it");

	property p_reg7_hold;
		@(posedge hclk) disable iff (!hresetn)
		s_live2 ##0 !$past(wr_pend && hit7) |-> $stable(reg7_r);
	endproperty : p_reg7_hold
	a_reg7_hold: assert property (p_reg7_hold) // [RULE16]
		else $error("reg7 changed without a write");

	property p_reg8_hold;
		@(posedge hclk) disable iff (!hresetn)
		s_live2 ##0 !$past(wr_pend && hit8) |-> $stable(reg8_r);
	endproperty : p_reg8_hold
	a_reg8_hold: assert property (p_reg8_hold) // [RULE16]
		else $error("reg8 changed without a write");

	// the slave never stretches a transfer and never signals an error
	property p_zero_wait;
		@(posedge hclk) disable iff (!hresetn)
		hreadyout && !hresp;
	endproperty : p_zero_wait
	a_zero_wait: assert property (p_zero_wait)
		else $error("wait state or error response");

	property p_rdata_hold;
		@(posedge hclk) disable iff (!hresetn)
		s_live2 ##0 !$past(take_rd) |-> $stable(hrdata);
	endproperty : p_rdata_hold
	a_rdata_hold: assert property (p_rdata_hold)
		else $error("read data moved without a read");
endmodule : prm_top

// file: tb/prm_top_test.sv
// self-checking bench for the pin remap block: ahb-lite register access and routed outputs.
// assumes one ahb master (this bench) and trigger sources held as steady levels.
`timescale 1ns/100ps
module prm_top_test;
	logic hclk, hresetn, hsel, hwrite, ts;
	logic [11:0] haddr;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] hwdata, q, v;
	logic [3:0] src, c;
	wire logic [31:0] hrdata;
	wire logic hreadyout, hresp, c1r, c1p, c2r, c2p, pps, sfe, rmii;
	wire logic [1:0] sfm, u8, u7, u6, eth;
	wire logic [11:0] maps;
	wire logic [4:0] trigs;
	int n_errors, comparisons, i, p;
	logic [31:0] tv [4] = '{32'h0, 32'h230, 32'h120, 32'h210};
	assign maps = {sfe, sfm, u8, u7, u6, rmii, eth};
	assign trigs = {c1r, c1p, c2r, c2p, pps};
	prm_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .ext_int_line_eleven(src[3]),
		.ext_int_line_fifteen(src[2]), .adv_timer_trigger_out(src[1]), .adv_timer_ch4(src[0]),
		.ts_pulse(ts), .conv1_regular_trig(c1r), .conv1_preempt_trig(c1p),
		.conv2_regular_trig(c2r), .conv2_preempt_trig(c2p), .ts_pulse_pin(pps),
		.serial_flash_if_enable(sfe), .serial_flash_pin_map(sfm), .uart_eight_pin_map(u8),
		.uart_seven_pin_map(u7), .usart_six_pin_map(u6), .eth_rmii_mode(rmii),
		.eth_rx_pin_map(eth));
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	function automatic logic [1:0] oh(input logic [3:0] k);
		oh = {k == 4'h1, k == 4'h0};
	endfunction : oh
	task report_and_stop();
		$display("checks %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : report_and_stop
	task check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	// bounded wait for hready sampled high at a rising edge
	task wait_rdy();
		int k;
		for (k = 0; k < 16; k++) begin
			@(posedge hclk);
			if (hreadyout === 1'b1)
				break;
		end
		if (k == 16) begin
			n_errors++;
			report_and_stop();
		end
	endtask : wait_rdy
	task bus(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [2:0] sz);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= prm_pkg::HTRANS_NONSEQ;
		hwrite <= wr;
		hsize <= sz;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
		q = hrdata;
		check({31'h0, hresp}, 32'h0);
	endtask : bus
	task wr32(input logic [11:0] a, input logic [31:0] d);
		bus(1'b1, a, d, prm_pkg::HSIZE_WORD);
	endtask : wr32
	task rd_chk(input logic [11:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0, prm_pkg::HSIZE_WORD);
		check(q, exp);
	endtask : rd_chk
	// routing lags the register by one edge; three edges leave margin
	task settle();
		repeat (3) @(posedge hclk);
		#1;
	endtask : settle
	task do_reset();
		hresetn <= 1'b0;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		#1;
	endtask : do_reset
	initial begin
		hsel = 1'b0;
		hwrite = 1'b0;
		haddr = 12'h000;
		htrans = 2'h0;
		hsize = 3'h2;
		hwdata = 32'h0;
		hresetn = 1'b0;
		src = 4'h9;
		ts = 1'b1;
		do_reset();
		check({20'h0, maps}, 32'h0);
		rd_chk(prm_pkg::REG7_OFFSET, 32'h0);
		rd_chk(prm_pkg::REG8_OFFSET, 32'h0);
		rd_chk(12'h008, 32'h0);
		$display("test reset values done");
		wr32(prm_pkg::REG7_OFFSET, 32'hFFFFFFFF);
		rd_chk(prm_pkg::REG7_OFFSET, 32'h0000033F);
		bus(1'b1, prm_pkg::REG7_OFFSET, 32'h0, 3'h0);
		rd_chk(prm_pkg::REG7_OFFSET, 32'h0000033F);
		$display("test reserved bits done");
		// two source patterns so a select stuck on either input shows up
		for (p = 0; p < 2; p++) begin
			src <= (p == 0) ? 4'h9 : 4'h6;
			for (i = 0; i < 4; i++) begin
				v = tv[i];
				wr32(prm_pkg::REG7_OFFSET, v);
				settle();
				check({27'h0, trigs}, {27'h0, v[5] ? src[1] : src[3], v[4] ? src[0] : src[2],
					v[9] ? src[1] : src[3], v[8] ? src[0] : src[2], 1'b0});
			end
		end
		$display("test trigger routing done");
		for (c = 4'h0; c < 4'h3; c++) begin
			v = {c, c, c, c == 4'h1, c == 4'h1, c[1:0], 16'hFFFF};
			wr32(prm_pkg::REG8_OFFSET, v);
			wr32(prm_pkg::REG7_OFFSET, {28'h0, 1'b1, c[2:0]});
			rd_chk(prm_pkg::REG8_OFFSET, {v[31:16], 16'h0});
			settle();
			check({20'h0, maps}, {20'h0, 1'b1, oh(c), oh(c), oh(c), oh(c), c == 4'h1, oh(c)});
			check({31'h0, pps}, {31'h0, c == 4'h1});
		end
		$display("test pin maps done");
		do_reset();
		check({20'h0, maps}, 32'h0);
		rd_chk(prm_pkg::REG8_OFFSET, 32'h0);
		$display("test second reset done");
		report_and_stop();
	end
endmodule : prm_top_test
